// file: hw/uar_pkg.sv
// Constants, field layout and state codes of the async serial receiver.
// Assumes a single 200 MHz APB clock; registers sit at word index * 4.
// Contract
// - Line is oversampled sixteen times per bit; shifter moves once per bit.
// - Async reception starts only while continuous_receive_enable is set.
// - After the stop bit, word moves to holding FIFO if room, flag set.
// - receive_ready_flag is read-only; clears once reads empty the FIFO.
// - Holding FIFO keeps two words while a third one shifts in.
// - Stop bit with FIFO full sets overrun_error and drops the shifted word.
// - Overrun clears only by clearing then setting continuous_receive_enable.
// - While overrun_error is set no word enters the holding FIFO.
// - A stop bit sampled low sets framing_error for that word.
// - Framing and ninth bits travel with each word; data reads advance them.
// - Completed reception raises the interrupt only when its enable is set.
// - Sync master is half-duplex; receive and transmit exclude each other.
// - synchronous_select set selects synchronous mode, clear asynchronous.
// - serial_port_enable hands both pins to the port as clock and data.
// - clock_source_master set makes the device drive the serial clock line; here only in synchronous mode.
// - Each bit is a majority of three samples on x16 edges seven to nine.
// - Frames are NRZ, LSB first: start, eight or nine data, one stop.
// - Baud generator runs at x16 or x64 the bit rate per high_baud_select.
package uar_pkg;

  // Register word indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_FLAGS  = 8'h0c;
  localparam logic [7:0] IDX_RXCTL  = 8'h18;
  localparam logic [7:0] IDX_TXDATA = 8'h19;
  localparam logic [7:0] IDX_RXDATA = 8'h1a;
  localparam logic [7:0] IDX_ENABLE = 8'h8c;
  localparam logic [7:0] IDX_TXCTL  = 8'h98;
  localparam logic [7:0] IDX_BAUD   = 8'h99;

  // Receive control/status fields
  localparam int RC_SERIAL_PORT_ENABLE = 7;
  localparam int RC_RX9  = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RC_FRAMING_ERROR = 2;
  localparam int RC_OVERRUN_ERROR = 1;
  localparam int RC_NINTH_RECEIVE_BIT = 0;

  // Transmit control/status fields
  localparam int TC_CLOCK_SOURCE_MASTER = 7;
  localparam int TC_TX9  = 6;
  localparam int TC_TRANSMIT_ENABLE = 5;
  localparam int TC_SYNC = 4;
  localparam int TC_HIGH_BAUD_SELECT = 2;
  localparam int TC_TRMT = 1;
  localparam int TC_TX9D = 0;

  // Flag and enable position of the receive event
  localparam int FL_RECEIVE_READY_FLAG = 5;
  localparam int EN_RECEIVE_INTERRUPT_ENABLE = 5;

  // Reset values
  localparam logic [7:0] RST_TXCTL  = 8'h02;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // Oversampling: x16 edges per bit, samples on edges 7, 8 and 9
  localparam logic [3:0] PH_SAMPLE1 = 4'h6;
  localparam logic [3:0] PH_SAMPLE2 = 4'h7;
  localparam logic [3:0] PH_DECIDE  = 4'h8;
  localparam logic [1:0] PRESC_LAST = 2'h3;  // x64 to x16 divide by four
  localparam int         RX_FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_start = 2'b01,
    st_data  = 2'b10,
    st_stop  = 2'b11
  } uar_state_e;

endpackage

// file: hw/uar_rx.sv
// Async serial receive path with its APB register file and pin control.
// Assumes one clock pclk; the data pin is asynchronous and is synchronised.
`timescale 1ns/10ps
module uar_rx
  import uar_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  output logic             rx_irq
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = PW + 1;

  // Byte address match for a word index
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // Two-of-three vote
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Ring pointer advance, works for any depth
  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  logic            serial_port_enable;
  logic            rx9;
  logic            single_receive_enable;
  logic            continuous_receive_enable;
  logic            clock_source_master;
  logic            tx9;
  logic            transmit_enable;
  logic            sync;
  logic            high_baud_select;
  logic            tx9d;
  logic [7:0]      txdata;
  logic [7:0]      pie;
  logic [7:0]      baud_divisor;
  logic            overrun_error;
  logic            pop_armed;
  logic [7:0]      next_rdata;
  logic [7:0]      brg_cnt;
  logic [1:0]      presc;
  logic            rx_meta;
  logic            rx_sync;
  uar_state_e      rx_state;
  logic [3:0]      phase;
  logic [1:0]      votes;
  logic [3:0]      bitn;
  logic [8:0]      shreg;
  logic [9:0]      mem [FIFO_DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   rd_ptr;
  logic [CW-1:0]   count;
  logic            ck_q;

  // Bus decode; zero wait states, unmapped addresses answer with an error
  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire s_fl   = hit(paddr, IDX_FLAGS);
  wire s_rc   = hit(paddr, IDX_RXCTL);
  wire s_txd  = hit(paddr, IDX_TXDATA);
  wire s_rxd  = hit(paddr, IDX_RXDATA);
  wire s_en   = hit(paddr, IDX_ENABLE);
  wire s_tc   = hit(paddr, IDX_TXCTL);
  wire s_bd   = hit(paddr, IDX_BAUD);
  wire mapped = s_fl | s_rc | s_txd | s_rxd | s_en | s_tc | s_bd;
  wire wr     = access & pwrite;

  assign pready  = access;
  assign pslverr = access & ~mapped;

  // FIFO state and head entry {framing, ninth, data}
  wire       empty = (count == '0);
  wire       full  = (count == CW'(FIFO_DEPTH));
  wire [9:0] head  = mem[rd_ptr];
  wire       receive_ready_flag  = ~empty;
  wire       pop   = access & pop_armed;

  // Receive runs only in async mode with port and receive enabled
  wire rx_en = serial_port_enable & ~sync & continuous_receive_enable;

  // Baud generator runs only while some direction is enabled
  wire brg_run  = serial_port_enable & (continuous_receive_enable | single_receive_enable | transmit_enable);
  wire brg_tick = brg_run & (brg_cnt == 8'h00);
  // Low baud setting divides a x64 tick down to x16
  wire samp_tick = brg_tick & (high_baud_select | (presc == PRESC_LAST));

  // Bit decision on the ninth edge, voting the two stored samples and the current one
  wire bit_dec   = samp_tick & (phase == PH_DECIDE);
  wire cur_bit   = maj3({votes, rx_sync});
  wire stop_done = rx_en & (rx_state == st_stop) & bit_dec;
  wire push      = stop_done & ~full & ~overrun_error;
  wire [7:0] word_data  = rx9 ? shreg[7:0] : shreg[8:1];
  wire       word_ninth = rx9 & shreg[8];

  // Read mux; status bits of the head word are shown in the control reg
  always_comb begin
    next_rdata = 8'h00;
    if (s_fl) begin
      next_rdata[FL_RECEIVE_READY_FLAG] = receive_ready_flag;
    end
    if (s_rc) begin
      next_rdata[RC_SERIAL_PORT_ENABLE] = serial_port_enable;
      next_rdata[RC_RX9]  = rx9;
      next_rdata[RC_SINGLE_RECEIVE_ENABLE] = single_receive_enable;
      next_rdata[RC_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable;
      next_rdata[RC_FRAMING_ERROR] = head[9];
      next_rdata[RC_OVERRUN_ERROR] = overrun_error;
      next_rdata[RC_NINTH_RECEIVE_BIT] = head[8];
    end
    if (s_txd) begin
      next_rdata = txdata;
    end
    if (s_rxd) begin
      next_rdata = head[7:0];
    end
    if (s_en) begin
      next_rdata = pie;
    end
    if (s_tc) begin
      next_rdata[TC_CLOCK_SOURCE_MASTER] = clock_source_master;
      next_rdata[TC_TX9]  = tx9;
      next_rdata[TC_TRANSMIT_ENABLE] = transmit_enable;
      next_rdata[TC_SYNC] = sync;
      next_rdata[TC_HIGH_BAUD_SELECT] = high_baud_select;
      next_rdata[TC_TRMT] = 1'b1;                 // No transmitter: always idle
      next_rdata[TC_TX9D] = tx9d;
    end
    if (s_bd) begin
      next_rdata = baud_divisor;
    end
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0000_0000;
      pop_armed <= 1'b0;
    end else if (setup) begin
      prdata    <= {24'h00_0000, next_rdata};
      // Pop only a word that was really returned, never one that lands late
      pop_armed <= ~pwrite & s_rxd & ~empty;
    end else if (access) begin
      pop_armed <= 1'b0;
    end
  end

  // Control register writes; status and flag bits are not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_enable <= RST_ZERO[RC_SERIAL_PORT_ENABLE];
      rx9  <= RST_ZERO[RC_RX9];
      single_receive_enable <= RST_ZERO[RC_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable <= RST_ZERO[RC_CONTINUOUS_RECEIVE_ENABLE];
    end else if (wr & s_rc) begin
      serial_port_enable <= pwdata[RC_SERIAL_PORT_ENABLE];
      rx9  <= pwdata[RC_RX9];
      single_receive_enable <= pwdata[RC_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable <= pwdata[RC_CONTINUOUS_RECEIVE_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_master <= RST_TXCTL[TC_CLOCK_SOURCE_MASTER];
      tx9  <= RST_TXCTL[TC_TX9];
      transmit_enable <= RST_TXCTL[TC_TRANSMIT_ENABLE];
      sync <= RST_TXCTL[TC_SYNC];
      high_baud_select <= RST_TXCTL[TC_HIGH_BAUD_SELECT];
      tx9d <= RST_TXCTL[TC_TX9D];
    end else if (wr & s_tc) begin
      clock_source_master <= pwdata[TC_CLOCK_SOURCE_MASTER];
      tx9  <= pwdata[TC_TX9];
      transmit_enable <= pwdata[TC_TRANSMIT_ENABLE];
      sync <= pwdata[TC_SYNC];
      high_baud_select <= pwdata[TC_HIGH_BAUD_SELECT];
      tx9d <= pwdata[TC_TX9D];
    end
  end

  // Plain storage registers; flag register writes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txdata       <= RST_ZERO;
      pie          <= RST_ZERO;
      baud_divisor <= RST_ZERO;
    end else if (wr) begin
      if (s_txd) txdata       <= pwdata[7:0];
      if (s_en)  pie          <= pwdata[7:0];
      if (s_bd)  baud_divisor <= pwdata[7:0];
    end
  end

  // Baud counter; held at zero when idle so the first tick comes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt <= 8'h00;
    end else if (!brg_run) begin
      brg_cnt <= 8'h00;
    end else if (brg_tick) begin
      brg_cnt <= baud_divisor;
    end else begin
      brg_cnt <= brg_cnt - 8'h01;
    end
  end

  // Prescaler for the low baud setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 2'h0;
    end else if (!brg_run) begin
      presc <= 2'h0;
    end else if (brg_tick) begin
      presc <= presc + 2'h1;
    end
  end

  // Two-flop synchroniser; idle line is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_data_line_in;
      rx_sync <= rx_meta;
    end
  end

  // Frame sequencer: phase counts x16 edges, state changes at the decision
  // edge, so each later decision falls sixteen edges after the previous one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= st_idle;
      phase    <= 4'h0;
      votes    <= 2'b11;
      bitn     <= 4'h0;
      shreg    <= 9'h000;
    end else if (!rx_en) begin
      // Clearing the enable resets the receive logic mid-frame
      rx_state <= st_idle;
      phase    <= 4'h0;
    end else if (samp_tick) begin
      phase <= phase + 4'h1;
      if (phase == PH_SAMPLE1 || phase == PH_SAMPLE2) begin
        votes <= {votes[0], rx_sync};
      end
      unique case (rx_state)
        st_idle: begin
          if (!rx_sync) begin
            rx_state <= st_start;
            phase    <= 4'h1;                     // Detect edge is edge one
          end
        end
        st_start: begin
          if (bit_dec) begin
            // A high start vote is a glitch, not a frame
            rx_state <= cur_bit ? st_idle : st_data;
            bitn     <= 4'h0;
          end
        end
        st_data: begin
          if (bit_dec) begin
            shreg <= {cur_bit, shreg[8:1]};
            bitn  <= bitn + 4'h1;
            if (bitn == (rx9 ? 4'h8 : 4'h7)) begin
              rx_state <= st_stop;
            end
          end
        end
        st_stop: begin
          // Back to idle early so the next start edge is not missed
          if (bit_dec) begin
            rx_state <= st_idle;
          end
        end
      endcase
    end
  end

  // Overrun: set by a stop bit with the FIFO full, dropped by clearing enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error <= 1'b0;
    end else if (stop_done & full) begin
      overrun_error <= 1'b1;
    end else if (!continuous_receive_enable) begin
      overrun_error <= 1'b0;
    end
  end

  // Holding FIFO storage, framing bit is the inverse of the stop vote;
  // cleared at reset so data and status read zero before the first word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem[i] <= {2'b00, RST_ZERO};
      end
    end else if (push) begin
      mem[wr_ptr] <= {~cur_bit, word_ninth, word_data};
    end
  end

  // FIFO pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= nxt(wr_ptr);
      if (pop)  rd_ptr <= nxt(rd_ptr);
      if (push & ~pop) count <= count + CW'(1);
      if (pop & ~push) count <= count - CW'(1);
    end
  end

  // Pin ownership: data line driven only in synchronous transmit, master or slave,
  // which excludes any receive enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_line_oe  <= 1'b0;
      serial_clock_line_oe <= 1'b0;
    end else begin
      serial_data_line_oe  <= serial_port_enable & sync & transmit_enable & ~(continuous_receive_enable | single_receive_enable);
      serial_clock_line_oe <= serial_port_enable & sync & clock_source_master;
    end
  end

  // Master clock idles high and toggles on baud ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= 1'b1;
    end else if (!(serial_port_enable & sync & clock_source_master) || !brg_run) begin
      ck_q <= 1'b1;
    end else if (brg_tick) begin
      ck_q <= ~ck_q;
    end
  end

  assign serial_clock_line_out = ck_q;
  assign serial_data_line_out  = 1'b1;            // Mark level; no transmitter
  assign rx_irq = receive_ready_flag & pie[EN_RECEIVE_INTERRUPT_ENABLE];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_push_flag;
    push |=> receive_ready_flag;
  endproperty
  a_push_flag: assert property (p_push_flag)
    else $error("ready flag not set after push");

  property p_flag_clear;
    (pop && count == CW'(1) && !push) |=> !receive_ready_flag && !rx_irq;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("ready flag kept after last read");

  property p_overrun;
    (stop_done && full && !overrun_error) |=> overrun_error && $stable(wr_ptr)
                                     && (full || $past(pop));
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or word stored");

  property p_block;
    overrun_error |-> !push;
  endproperty
  a_block: assert property (p_block)
    else $error("word entered FIFO during overrun");

  property p_overrun_error_clear;
    (overrun_error && !continuous_receive_enable) |=> !overrun_error ##1 (!overrun_error || $past(stop_done));
  endproperty
  a_overrun_error_clear: assert property (p_overrun_error_clear)
    else $error("overrun kept after enable cleared");

  property p_framing_error_head;
    (push && empty && !pop) |=> head[9] != $past(cur_bit);
  endproperty
  a_framing_error_head: assert property (p_framing_error_head)
    else $error("framing status wrong for stored word");

  property p_rx_gate;
    (rx_state == st_idle && !rx_en) |=> rx_state == st_idle;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receiver started while disabled");

  property p_brg_reload;
    (brg_tick && $past(brg_run)) |=> (brg_cnt == $past(baud_divisor))
                                     || !brg_run;
  endproperty
  a_brg_reload: assert property (p_brg_reload)
    else $error("baud counter did not reload");

  property p_low_presc;
    (brg_tick && !high_baud_select && presc != PRESC_LAST) |-> !samp_tick;
  endproperty
  a_low_presc: assert property (p_low_presc)
    else $error("x64 tick not divided by four");

  c_push:    cover property (push);
  c_overrun: cover property (stop_done && full);
  c_full:    cover property (full && rx_state == st_data);
  c_framing_error:    cover property (push && !cur_bit);

endmodule

// file: verif/uar_tx_model.sv
// Remote asynchronous transmitter that drives the port's receive line.
// Assumes the bench hands it the bit time in pclk cycles for each frame.
`timescale 1ns/10ps
module uar_tx_model (
  output logic      line,
  input  wire logic pclk
);
  // Marking level between frames, so the receiver sees an idle high line
  initial begin
    line = 1'b1;
  end

  // One NRZ frame, LSB first; the stop level is set low only when asked
  task automatic send(input logic [8:0] d, input int nbits,
                      input logic stop, input int bit_cyc);
    logic lvl;
    for (int i = 0; i < nbits + 2; i++) begin
      if (i == 0) lvl = 1'b0;
      else if (i <= nbits) lvl = d[i-1];
      else lvl = stop;
      @(posedge pclk);
      line <= lvl;
      repeat (bit_cyc - 1) @(posedge pclk);
    end
    // Two idle bit times keep a low stop from looking like a new start
    @(posedge pclk);
    line <= 1'b1;
    repeat (2 * bit_cyc) @(posedge pclk);
  endtask
endmodule

// file: verif/usart_async_receiver_bench.sv
// Self-checking bench of the async receive path, with a queue model.
// Assumes uar_tx_model drives the receive line; APB master is here.
`timescale 1ns/10ps
module usart_async_receiver_bench;
  import uar_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         rx_line;
  wire         data_oe;
  wire         data_out;
  wire         clk_oe;
  wire         clk_out;
  wire         rx_irq;
  int          mismatches;
  int          n_tests;
  int          cyc;
  int          bit_cyc;
  logic [9:0]  q [$];
  logic [7:0]  ctl_m;
  logic        overrun_error_m;
  logic        receive_interrupt_enable_m;
  logic        nine_m;
  logic        sync_m;
  logic [31:0] r;
  logic        e;
  int          n_edges;
  logic        ck_last;
  logic [7:0]  ridx [7] = '{IDX_FLAGS, IDX_RXCTL, IDX_TXDATA, IDX_RXDATA,
                            IDX_ENABLE, IDX_TXCTL, IDX_BAUD};
  logic [7:0]  rval [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            RST_TXCTL, 8'h00};
  int          bdiv [3] = '{1, 0, 2};
  int          bcyc [3] = '{32, 64, 48};

  uar_rx i_uar_rx (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .serial_data_line_in   (rx_line),
    .serial_data_line_out  (data_out),
    .serial_data_line_oe   (data_oe),
    .serial_clock_line_out (clk_out),
    .serial_clock_line_oe  (clk_oe),
    .rx_irq                (rx_irq)
  );

  uar_tx_model i_uar_tx_model (
    .line (rx_line),
    .pclk (pclk)
  );

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hung handshake or frame must not stall the run for ever
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      $display("ERROR %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  // APB transfer: setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, d, x, y);
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d);
    logic y;
    apb(1'b0, idx, 8'h00, d, y);
  endtask

  // Send a frame and keep the FIFO model: two slots, overrun drops
  task automatic frame(input logic [8:0] d, input logic stop);
    i_uar_tx_model.send(d, nine_m ? 9 : 8, stop, bit_cyc);
    if (ctl_m[RC_SERIAL_PORT_ENABLE] && ctl_m[RC_CONTINUOUS_RECEIVE_ENABLE] && !sync_m && !overrun_error_m) begin
      if (q.size() < 2) q.push_back({~stop, nine_m & d[8], d[7:0]});
      else overrun_error_m = 1'b1;
    end
  endtask

  task automatic flag_check();
    logic [31:0] x;
    rdr(IDX_FLAGS, x);
    chk(x, {26'h0, q.size() != 0, 5'h00});
    chk({31'h0, rx_irq}, {31'h0, q.size() != 0 && receive_interrupt_enable_m});
  endtask

  // Status first, then data, as software must do it
  task automatic pop_check();
    logic [31:0] x;
    logic [31:0] m;
    m = nine_m ? 32'hff : 32'hfe;
    rdr(IDX_RXCTL, x);
    chk(x & m,
        {24'h0, ctl_m | {5'b0, q[0][9], overrun_error_m, q[0][8]}} & m);
    rdr(IDX_RXDATA, x);
    chk(x, {24'h0, q[0][7:0]});
    void'(q.pop_front());
    flag_check();
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {mismatches, n_tests, cyc} = '0;
    {ctl_m, overrun_error_m, receive_interrupt_enable_m, nine_m, sync_m} = '0;
    bit_cyc = 32;
    void'($urandom(32'hc13c));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values; receive control bit 0 reads zero after reset but is left out of the check
    for (int i = 0; i < 7; i++) begin
      rdr(ridx[i], r);
      chk(r & (ridx[i] == IDX_RXCTL ? 32'hfe : 32'hff), {24'h0, rval[i]});
    end
    wr(IDX_TXDATA, 8'h5a);
    rdr(IDX_TXDATA, r);
    chk(r, 32'h5a);
    wr(IDX_FLAGS, 8'hff);
    flag_check();
    apb(1'b0, 8'h01, 8'h00, r, e);
    chk({r[30:0], e}, 32'h1);
    // Setup order: divisor, speed, port on, interrupt, then receive on
    wr(IDX_BAUD, 8'h01);
    wr(IDX_TXCTL, 8'h04);
    wr(IDX_RXCTL, 8'h80);
    frame(9'h0a5, 1'b1);
    flag_check();
    wr(IDX_ENABLE, 8'h20);
    receive_interrupt_enable_m = 1'b1;
    wr(IDX_RXCTL, 8'h90);
    ctl_m = 8'h90;
    // Two words fill the FIFO, the third overruns, the fourth is blocked
    repeat (2) frame(9'($urandom() & 32'hff), 1'b1);
    flag_check();
    repeat (2) frame(9'($urandom() & 32'hff), 1'b1);
    repeat (2) pop_check();
    // Receive reset clears the overrun and lets words in again
    wr(IDX_RXCTL, 8'h80);
    wr(IDX_RXCTL, 8'h90);
    overrun_error_m = 1'b0;
    frame(9'h03c, 1'b1);
    pop_check();
    // Framing error travels with its own word only
    frame(9'h0f0, 1'b0);
    frame(9'h00f, 1'b1);
    repeat (2) pop_check();
    // Nine-bit frames carry the ninth bit into status
    wr(IDX_RXCTL, 8'hd0);
    ctl_m = 8'hd0;
    nine_m = 1'b1;
    frame(9'h155, 1'b1);
    frame(9'h0aa, 1'b1);
    repeat (2) pop_check();
    wr(IDX_RXCTL, 8'h90);
    ctl_m = 8'h90;
    nine_m = 1'b0;
    // Masked interrupt leaves the flag alone
    wr(IDX_ENABLE, 8'h00);
    receive_interrupt_enable_m = 1'b0;
    frame(9'h081, 1'b1);
    flag_check();
    pop_check();
    // Divisor and speed select set the bit time
    for (int i = 0; i < 3; i++) begin
      wr(IDX_BAUD, 8'(bdiv[i]));
      wr(IDX_TXCTL, bcyc[i] == 64 ? 8'h00 : 8'h04);
      bit_cyc = bcyc[i];
      frame(9'($urandom() & 32'hff), 1'b1);
      pop_check();
    end
    // Synchronous master: port drives clock; data pin half-duplex
    wr(IDX_TXCTL, 8'hb0);
    wr(IDX_RXCTL, 8'h80);
    ctl_m = 8'h80;
    sync_m = 1'b1;
    repeat (3) @(posedge pclk);
    chk({29'h0, data_out, clk_oe, data_oe}, 32'h7);
    // Master clock toggles once per baud tick, every divisor+1 cycles
    n_edges = 0;
    @(negedge pclk);
    ck_last = clk_out;
    repeat (30) begin
      @(negedge pclk);
      if (clk_out !== ck_last) n_edges++;
      ck_last = clk_out;
    end
    chk(32'(n_edges), 32'd10);
    wr(IDX_RXCTL, 8'h90);
    ctl_m = 8'h90;
    repeat (3) @(posedge pclk);
    chk({30'h0, clk_oe, data_oe}, 32'h2);
    frame(9'h066, 1'b1);
    flag_check();
    complete_run();
  end
endmodule
